// [bench/pol_fault_checker_assertions.sv]
// Concurrent checks on the fault supervisor's ports.
// Assumes binding to the supervisor top module, one clock domain.
`timescale 1ns/1ps
module pol_fault_checker (
   input wire logic               clk,                // Clock
   input wire logic               rstn,               // Reset, active low
   input wire logic [11:0]        vout,               // Output code
   input wire logic [11:0]        vset,               // Setpoint code
   input wire logic signed [11:0] temp,               // Temperature
   input wire logic               ramp_done,          // Ramp-down end
   input wire logic               re,                 // Read strobe
   input wire logic [15:0]        rdata,              // Read data
   input wire logic               hs_allow,           // High side ok
   input wire logic               ls_allow,           // Low side ok
   input wire logic               ls_force,           // Low side on
   input wire logic               seq_off,            // Ramp down
   input wire logic               restart,            // Retry pulse
   input wire logic               output_window_good  // Power good
);
   // ****************************************************
   // Helper logic
   // ****************************************************
   logic [7:0]  ot_cnt_r;    // Cycles at trip temperature
   logic [7:0]  ot_cnt_nxt;  // Next count
   logic [19:0] vo100;       // Output scaled by 100
   assign vo100 = 20'(vout) * 20'd100;
   // Saturating count, restarted by a retry
   always_comb
   begin
      if (temp < 12'sd1200 || restart)
         ot_cnt_nxt = 8'h00;
      else
         ot_cnt_nxt = (ot_cnt_r == 8'hff) ? ot_cnt_r : ot_cnt_r + 8'h01;
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ot_cnt_r <= 8'h00;
      else
         ot_cnt_r <= ot_cnt_nxt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ****************************************************
   // Assertions
   // ****************************************************
   restart_pulse_a: assert property (restart |=> !restart)
      else $error("restart pulse too long");
   restart_clean_a: assert property (restart |-> hs_allow && ls_allow && !seq_off && !ls_force)
      else $error("restart with drives off");
   cata_drive_a: assert property (ls_force |-> !hs_allow && ls_allow)
      else $error("forced low side with high side on");
   both_off_a: assert property ($fell(hs_allow) |-> ls_force || $fell(ls_allow))
      else $error("drives did not drop together");
   seq_start_a: assert property ($rose(seq_off) |-> hs_allow && ls_allow)
      else $error("ramp down began with drives off");
   seq_end_a: assert property (seq_off && hs_allow && ramp_done |=> !hs_allow && !ls_allow)
      else $error("drives held after ramp down");
   ot_trip_a: assert property (ot_cnt_r == 8'd245 |-> seq_off || !hs_allow)
      else $error("overtemperature trip missing");
   pg_high_a: assert property (vo100 > 20'(vset) * 20'd110 |=> !output_window_good)
      else $error("power good above window");
   pg_low_a: assert property (vo100 < 20'(vset) * 20'd75 |=> !output_window_good)
      else $error("power good below undervoltage");
   rd_idle_a: assert property (!re |=> rdata == 16'h0000)
      else $error("read data outside read cycle");
   cover property (restart);
   cover property ($rose(ls_force));
   cover property ($rose(output_window_good));
endmodule

bind pol_fault_protection_supervisor pol_fault_checker i_chk (
   .clk, .rstn, .vout, .vset, .temp, .ramp_done, .re, .rdata, .hs_allow,
   .ls_allow, .ls_force, .seq_off, .restart, .output_window_good
);

// [bench/ramp_partner.sv]
// Ramp generator model facing the supervisor's ramp-down request.
// Assumes the supervisor's clock and reset.
`timescale 1ns/1ps
module ramp_partner (
   input  wire logic       clk,       // Clock
   input  wire logic       rstn,      // Reset, active low
   input  wire logic       seq_off,   // Ramp-down request
   input  wire logic [7:0] lag,       // Ramp length in cycles
   output logic            ramp_done  // Ramp finished
);
   logic [7:0] cnt_r;  // Cycles since request
   // Ramp ends lag+1 cycles after the request, holds while requested
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_r     <= 8'h00;
         ramp_done <= 1'b0;
      end
      else
      begin
         cnt_r     <= (seq_off && cnt_r != 8'hff) ? cnt_r + 8'h01 : (seq_off ? cnt_r : 8'h00);
         ramp_done <= seq_off && cnt_r >= lag;
      end
   end
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the fault supervisor.
// Assumes the ramp model and the bound checker.
`timescale 1ns/1ps
module tb_top;
   import pol_fault_pkg::*;
   logic               clk = 1'b0;           // 40 MHz clock
   logic               rstn = 1'b0;          // Reset
   logic [11:0]        vout = 12'h3e8;       // Output code
   logic [11:0]        vset = 12'h3e8;       // Setpoint code
   logic signed [11:0] temp = 12'sh0fa;      // 25.0 C
   logic signed [11:0] trk_err = 12'sh000;   // Tracking error
   logic               ramp_up = 1'b0;       // Rising ramp
   logic               turnoff_cmd = 1'b0;   // Manager off
   logic [AW-1:0]      addr = '0;            // Register address
   logic [DW-1:0]      wdata = '0;           // Write data
   logic               we = 1'b0;            // Write strobe
   logic               re = 1'b0;            // Read strobe
   logic [DW-1:0]      rdata;                // Read data
   logic               ramp_done, hs_allow, ls_allow, ls_force;
   logic               seq_off, restart, output_window_good, irq;
   logic [7:0]         lag = 8'h05;          // Slow ramp down
   logic               rd_seen = 1'b0;       // Read answer due
   logic [DW-1:0]      exp_q[$];             // Expected reads
   logic [31:0]        seed = 32'h456c;      // Random state
   int                 n_mismatch = 0;
   int                 compares = 0;
   int                 cyc = 0;
   int                 n;
   int                 dly[4] = '{0, 5, 10, 20};

   initial forever #12.5 clk = ~clk;

   pol_fault_protection_supervisor #(.HICCUP(50), .PGD1(5), .PGD2(10), .PGD3(20)) i_dut (
      .clk, .rstn, .vout, .vset, .temp, .trk_err, .ramp_up, .ramp_done, .turnoff_cmd,
      .addr, .wdata, .we, .re, .rdata, .hs_allow, .ls_allow, .ls_force, .seq_off,
      .restart, .output_window_good, .irq);
   ramp_partner i_ramp (.clk, .rstn, .seq_off, .lag, .ramp_done);

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_out(logic got, logic exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t output %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_rd(logic [DW-1:0] got, logic [DW-1:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
      addr <= a;
      re <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      re <= 1'b0;
      @(posedge clk);
   endtask
   // Bounded wait for a level on a design output
   task automatic wait_lv(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim)
      begin
         @(posedge clk);
         k++;
      end
   endtask

   // Read answers one cycle after the strobe; cycle ceiling
   always @(posedge clk)
   begin
      if (rd_seen)
         chk_rd(rdata, exp_q.pop_front());
      rd_seen <= re;
      cyc++;
      if (cyc > 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   // ****************************************************
   // Scenarios
   // ****************************************************
   initial
   begin
      tick(20);
      rstn <= 1'b1;
      tick(1);
      for (int a = 0; a < 6; a++)
         rd(AW'(a), (a == 2) ? 16'h0010 : (a == 4) ? 16'h0042 : 16'h0000);
      $display("test reset done");
      wr(A_MASK, 16'h001f);
      for (int s = 0; s < 4; s++)
      begin
         wr(A_CTRL, 16'(s) << 8);
         vout <= 12'h4b0;
         tick(3);
         chk_out(output_window_good, 1'b0);
         seed = lfsr_next(seed);
         vout <= 12'h3b6 + 12'(seed % 100);
         wait_lv(output_window_good, 1'b1, 100, n);
         chk_out(n >= dly[s] && n <= dly[s] + 4, 1'b1);
      end
      wr(A_CTRL, 16'h0000);
      wr(A_THR, 16'h0008);
      vout <= 12'h42e;
      tick(3);
      chk_out(output_window_good, 1'b0);
      wr(A_THR, 16'h0000);
      wait_lv(output_window_good, 1'b1, 10, n);
      chk_out(output_window_good, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         wr(A_CTRL, i ? 16'h0040 : 16'h0000);
         turnoff_cmd <= 1'b1;
         tick(3);
         chk_out(output_window_good, i == 0);
         turnoff_cmd <= 1'b0;
         wait_lv(output_window_good, 1'b1, 10, n);
      end
      $display("test power good done");
      wr(A_CTRL, 16'h0000);
      wr(A_STAT, 16'h001f);
      wr(A_MASK, 16'h0001);
      vout <= 12'h2f8;
      tick(300);
      chk_out(seq_off, 1'b0);
      vout <= 12'h1f4;
      tick(3);
      chk_out(output_window_good, 1'b0);
      vout <= 12'h2f8;
      wr(A_THR, 16'h0003);
      wait_lv(seq_off, 1'b1, 300, n);
      chk_out(n >= 238 && n <= 244, 1'b1);
      chk_out(hs_allow, 1'b1);
      wait_lv(hs_allow, 1'b0, 20, n);
      chk_out(n >= 5 && !ls_allow, 1'b1);
      chk_out(irq, 1'b1);
      rd(A_STAT, 16'h0011);
      wr(A_STAT, 16'h001f);
      chk_out(irq, 1'b0);
      vout <= 12'h3e8;
      wr(A_THR, 16'h0000);
      wait_lv(restart, 1'b1, 80, n);
      chk_out(restart, 1'b1);
      $display("test undervoltage done");
      wr(A_CTRL, 16'h0012);
      temp <= 12'sd1200;
      wait_lv(hs_allow, 1'b0, 300, n);
      chk_out(seq_off || ls_allow, 1'b0);
      rd(A_LIVE, 16'h0117);
      temp <= 12'sd1090;
      wr(A_CTRL, 16'h0412);
      tick(60);
      chk_out(hs_allow, 1'b0);
      temp <= 12'sd1083;
      tick(2);
      rd(A_LIVE, 16'h0112);
      tick(60);
      chk_out(hs_allow, 1'b0);
      wr(A_CTRL, 16'h0412);
      wait_lv(hs_allow, 1'b1, 5, n);
      chk_out(hs_allow, 1'b1);
      temp <= 12'sh0fa;
      $display("test overtemperature done");
      wr(A_CTRL, 16'h0000);
      ramp_up <= 1'b1;
      trk_err <= 12'sd300;
      tick(300);
      chk_out(hs_allow, 1'b1);
      wr(A_CTRL, 16'h0028);
      for (int i = 0; i < 2; i++)
      begin
         ramp_up <= 1'b1;
         trk_err <= i ? -12'sd300 : 12'sd300;
         wait_lv(ls_force, 1'b1, 300, n);
         chk_out(ls_force && !hs_allow && ls_allow, 1'b1);
         trk_err <= 12'sh000;
         ramp_up <= 1'b0;
         wait_lv(restart, 1'b1, 80, n);
         chk_out(restart, 1'b1);
         tick(2);
      end
      $display("test tracking done");
      tick(4);
      end_sim();
   end
endmodule

// [logic/pol_fault_pkg.sv]
// Constants, register map and state codes of the fault supervisor.
// Assumes a 40 MHz clock and measurements arriving on that clock.
//
// Functional notes
// - Undervoltage trips below 75..90 percent setpoint
// - Fault trips after 6 us continuous crossing
// - Undervoltage/overtemperature: sequenced off, critical selectable
// - Sequenced off waits for ramp-down completion
// - Critical off drops both switch drives
// - Catastrophic off: high side off, low on
// - Overtemp shutdown at 120 C, restart later
// - Shutdown clears when warning flag drops
// - Tracking check optional, ramp-up only, 250 mV
// - Warning at 110 C, 1.7 C hysteresis, readable
// - Power good follows the output window
// - Window 90/95 low, 110/105 high
// - Power good rise delay 0/10/50/150 ms
// - Power good drops at undervoltage or command
package pol_fault_pkg;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_KHZ    = 40000;                        // Clock rate
   localparam int DET_NS     = 6000;                         // Detection delay
   localparam int DET_CYC    = (DET_NS * CLK_KHZ + 999999) / 1000000;
   localparam int HICCUP_MS  = 130;                          // Retry interval
   localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
   localparam int PGD1_MS    = 10;                           // Good delays
   localparam int PGD2_MS    = 50;
   localparam int PGD3_MS    = 150;
   localparam int PGD1_CYC   = PGD1_MS * CLK_KHZ;
   localparam int PGD2_CYC   = PGD2_MS * CLK_KHZ;
   localparam int PGD3_CYC   = PGD3_MS * CLK_KHZ;
   localparam int DET_W      = 8;                            // Filter width
   localparam int CNT_W      = 23;                           // Long counters

   // ****************************************************
   // Register map and fields
   // ****************************************************
   localparam int         AW     = 3;
   localparam int         DW     = 16;
   localparam logic [2:0] A_CTRL = 3'h0;                     // Control
   localparam logic [2:0] A_THR  = 3'h1;                     // Thresholds
   localparam logic [2:0] A_STAT = 3'h2;                     // Events, w1c
   localparam logic [2:0] A_MASK = 3'h3;                     // Event mask
   localparam logic [2:0] A_LIVE = 3'h4;                     // Live state
   localparam int C_UVL  = 0;                                // Latch bits
   localparam int C_OTL  = 1;
   localparam int C_TKL  = 2;
   localparam int C_TKEN = 3;                                // Tracking on
   localparam int C_CRIT = 4;                                // Critical off
   localparam int C_CATA = 5;                                // Catastrophic
   localparam int C_PGCM = 6;                                // Good at cmd
   localparam int C_PGD  = 8;                                // Delay, 2 bits
   localparam int C_CLR  = 10;                               // Clear pulse
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [3:0]  THR_RST  = 4'h0;
   localparam logic [15:0] CTRL_WM  = 16'h037f;              // Stored bits
   localparam int F_UV = 0;                                  // Fault index
   localparam int F_OT = 1;
   localparam int F_TK = 2;
   localparam int NEV  = 5;                                  // Event bits
   localparam int E_WN = 3;
   localparam int E_PG = 4;

   // ****************************************************
   // Thresholds
   // ****************************************************
   localparam logic [6:0]  UV_BASE  = 7'h4b;                 // 75 percent
   localparam logic [6:0]  PCT_STEP = 7'h05;
   localparam logic [6:0]  PGL_BASE = 7'h5a;                 // 90 percent
   localparam logic [6:0]  PGU_BASE = 7'h6e;                 // 110 percent
   localparam logic [6:0]  PCT_FULL = 7'h64;                 // 100 percent
   localparam logic signed [11:0] OT_TRIP  = 12'sh4b0;       // 120.0 C
   localparam logic signed [11:0] WARN_ON  = 12'sh44c;       // 110.0 C
   localparam logic signed [11:0] WARN_OFF = 12'sh43b;       // 108.3 C
   localparam logic signed [11:0] TRK_MV   = 12'sh0fa;       // 250 mV

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SEQ = 3'b010,
      ST_OFF = 3'b100
   } state_t;

endpackage

// [logic/pol_fault_protection_supervisor.sv]
// Fault supervisor: undervoltage, overtemperature, tracking, power good.
// Assumes measurements, ramp flags and commands come from logic on clk.
`timescale 1ns/1ps
module pol_fault_protection_supervisor #(
   parameter int HICCUP = pol_fault_pkg::HICCUP_CYC,         // Retry cycles
   parameter int PGD1   = pol_fault_pkg::PGD1_CYC,           // 10 ms
   parameter int PGD2   = pol_fault_pkg::PGD2_CYC,           // 50 ms
   parameter int PGD3   = pol_fault_pkg::PGD3_CYC            // 150 ms
) (
   input  wire logic                          clk,           // 40 MHz
   input  wire logic                          rstn,          // Async reset
   input  wire logic [11:0]                   vout,          // Output code
   input  wire logic [11:0]                   vset,          // Setpoint code
   input  wire logic signed [11:0]            temp,          // 0.1 C units
   input  wire logic signed [11:0]            trk_err,       // Error, mV
   input  wire logic                          ramp_up,       // Rising ramp
   input  wire logic                          ramp_done,     // Ramp-down end
   input  wire logic                          turnoff_cmd,   // Manager off
   input  wire logic [pol_fault_pkg::AW-1:0]  addr,          // Reg address
   input  wire logic [pol_fault_pkg::DW-1:0]  wdata,         // Write data
   input  wire logic                          we,            // Write strobe
   input  wire logic                          re,            // Read strobe
   output logic [pol_fault_pkg::DW-1:0]       rdata,         // Read data
   output logic                               hs_allow,      // High side ok
   output logic                               ls_allow,      // Low side ok
   output logic                               ls_force,      // Low side on
   output logic                               seq_off,       // Ramp down
   output logic                               restart,       // Retry pulse
   output logic                               output_window_good, // Good
   output logic                               irq            // Interrupt
);
   import pol_fault_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      state_t                st;        // Supervisor state
      logic [DW-1:0]         ctrl;      // Control register
      logic [3:0]            thr;       // Threshold selects
      logic [NEV-1:0]        stat;      // Sticky events
      logic [NEV-1:0]        mask;      // Event enables
      logic [2:0][DET_W-1:0] det;       // Detection filters
      logic [2:0]            cause;     // Faults behind the off
      logic                  ot_shut;   // Overtemp shutdown held
      logic                  warn;      // Warning flag
      logic                  pg;        // Power good
      logic [CNT_W-1:0]      pg_cnt;    // Good delay count
      logic [CNT_W-1:0]      hic_cnt;   // Retry count
      logic                  hs;        // High side permit
      logic                  ls;        // Low side permit
      logic                  lsf;       // Low side forced
      logic                  seq;       // Ramp-down request
      logic                  rst_p;     // Restart pulse
      logic                  irq;       // Interrupt level
      logic [DW-1:0]         rdata;     // Read data
   } sv_t;

   sv_t s_r;                            // Registered state
   sv_t s_nxt;                          // Next state

   // Scales a code by a percent figure
   function automatic logic [18:0] scaled(input logic [11:0] v, input logic [6:0] p);
      scaled = v * p;
   endfunction

   // Good delay for a select code
   function automatic logic [CNT_W-1:0] pg_delay(input logic [1:0] sel);
      unique case (sel)
         2'h0:    pg_delay = '0;
         2'h1:    pg_delay = CNT_W'(PGD1);
         2'h2:    pg_delay = CNT_W'(PGD2);
         default: pg_delay = CNT_W'(PGD3);
      endcase
   endfunction

   logic [18:0]    v100;                // Output times 100
   logic [18:0]    uv_lim;              // Undervoltage limit
   logic [18:0]    lo_lim;              // Window low limit
   logic [18:0]    hi_lim;              // Window high limit
   logic [2:0]     cond;                // Raw fault conditions
   logic [2:0]     trip;                // Filtered trips
   logic [NEV-1:0] ev;                  // Events this cycle
   logic           inwin;               // Inside good window
   logic           clr;                 // Clear command
   logic           crit;                // Critical off wanted
   logic           latch;               // Latched fault held
   logic [DW-1:0]  rd;                  // Read mux

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rst_p = 1'b0;
      rd = '0;
      ev = '0;
      crit = 1'b0;
      // Limits from the threshold selects
      v100   = scaled(vout, PCT_FULL);
      uv_lim = scaled(vset, 7'(UV_BASE + PCT_STEP * s_r.thr[1:0]));
      lo_lim = scaled(vset, s_r.thr[2] ? 7'(PGL_BASE + PCT_STEP) : PGL_BASE);
      hi_lim = scaled(vset, s_r.thr[3] ? 7'(PGU_BASE - PCT_STEP) : PGU_BASE);
      inwin  = (v100 >= lo_lim) && (v100 <= hi_lim);
      // Raw conditions; undervoltage ignored while ramping up
      cond[F_UV] = !ramp_up && (v100 < uv_lim);
      cond[F_OT] = temp >= OT_TRIP;
      cond[F_TK] = s_r.ctrl[C_TKEN] && ramp_up &&
                   ((trk_err > TRK_MV) || (trk_err < -TRK_MV));
      // Detection filters, restart on any gap
      for (int i = 0; i < 3; i++)
      begin
         trip[i] = cond[i] && (s_r.det[i] == DET_W'(DET_CYC - 1));
         if (!cond[i])
         begin
            s_nxt.det[i] = '0;
         end
         else if (!trip[i])
         begin
            s_nxt.det[i] = s_r.det[i] + 1'b1;
         end
      end
      // Warning flag with hysteresis
      if (!s_r.warn && temp >= WARN_ON)
      begin
         s_nxt.warn = 1'b1;
         ev[E_WN] = 1'b1;
      end
      else if (s_r.warn && temp <= WARN_OFF)
      begin
         s_nxt.warn = 1'b0;
      end
      // Shutdown held until warning drops
      if (trip[F_OT])
      begin
         s_nxt.ot_shut = 1'b1;
      end
      else if (!s_nxt.warn)
      begin
         s_nxt.ot_shut = 1'b0;
      end
      clr = we && (addr == A_CTRL) && wdata[C_CLR];
      latch = |(s_r.cause & {s_r.ctrl[C_TKL], s_r.ctrl[C_OTL], s_r.ctrl[C_UVL]});
      // Supervisor sequence
      unique case (s_r.st)
         ST_RUN:
         begin
            if (|trip)
            begin
               ev[2:0] = trip;
               s_nxt.cause = trip;
               crit = ((trip[F_UV] || trip[F_OT]) && s_r.ctrl[C_CRIT]) || trip[F_TK];
               if (trip[F_TK] && s_r.ctrl[C_CATA])
               begin
                  // High side off, low side held on
                  s_nxt.hs = 1'b0;
                  s_nxt.ls = 1'b1;
                  s_nxt.lsf = 1'b1;
                  s_nxt.st = ST_OFF;
               end
               else if (crit)
               begin
                  // Both drives off at once
                  s_nxt.hs = 1'b0;
                  s_nxt.ls = 1'b0;
                  s_nxt.st = ST_OFF;
               end
               else
               begin
                  // Ramp generator applies delay and slew
                  s_nxt.seq = 1'b1;
                  s_nxt.st = ST_SEQ;
               end
            end
         end
         ST_SEQ:
         begin
            // Stop switching when ramp-down is finished
            if (ramp_done)
            begin
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b0;
               s_nxt.st = ST_OFF;
            end
         end
         ST_OFF:
         begin
            if (latch)
            begin
               // Wait for the manager to clear
               if (clr && !s_r.ot_shut)
               begin
                  s_nxt.st = ST_RUN;
               end
            end
            else if (s_r.hic_cnt >= CNT_W'(HICCUP - 1))
            begin
               s_nxt.hic_cnt = '0;
               if (!s_r.ot_shut)
               begin
                  s_nxt.st = ST_RUN;
               end
            end
            else
            begin
               s_nxt.hic_cnt = s_r.hic_cnt + 1'b1;
            end
            // Restart clears the off condition
            if (s_nxt.st == ST_RUN)
            begin
               s_nxt.hs = 1'b1;
               s_nxt.ls = 1'b1;
               s_nxt.lsf = 1'b0;
               s_nxt.seq = 1'b0;
               s_nxt.cause = '0;
               s_nxt.hic_cnt = '0;
               s_nxt.rst_p = 1'b1;
               s_nxt.det = '0;
            end
         end
      endcase
      // Power good with rise delay and off conditions
      if (!s_r.pg)
      begin
         // A standing turn-off command keeps the rise from restarting
         if (!inwin || (s_r.ctrl[C_PGCM] && turnoff_cmd))
         begin
            s_nxt.pg_cnt = '0;
         end
         else if (s_r.pg_cnt >= pg_delay(s_r.ctrl[C_PGD +: 2]))
         begin
            s_nxt.pg = 1'b1;
            s_nxt.pg_cnt = '0;
         end
         else
         begin
            s_nxt.pg_cnt = s_r.pg_cnt + 1'b1;
         end
      end
      else if ((s_r.ctrl[C_PGCM] && turnoff_cmd) || v100 <= uv_lim || v100 > hi_lim)
      begin
         s_nxt.pg = 1'b0;
      end
      ev[E_PG] = s_nxt.pg != s_r.pg;
      // Register writes
      if (we)
      begin
         unique case (addr)
            A_CTRL:  s_nxt.ctrl = wdata & CTRL_WM;
            A_THR:   s_nxt.thr = wdata[3:0];
            A_STAT:  s_nxt.stat = s_r.stat & ~wdata[NEV-1:0];
            A_MASK:  s_nxt.mask = wdata[NEV-1:0];
            default: ;
         endcase
      end
      // New events win over a clear
      s_nxt.stat = s_nxt.stat | ev;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
      // Register reads, unmapped read zero
      unique case (addr)
         A_CTRL:  rd = s_r.ctrl;
         A_THR:   rd = DW'(s_r.thr);
         A_STAT:  rd = DW'(s_r.stat);
         A_MASK:  rd = DW'(s_r.mask);
         A_LIVE:  rd = DW'({s_r.st, s_r.cause, s_r.ot_shut, s_r.pg, s_r.warn});
         default: rd = '0;
      endcase
      s_nxt.rdata = re ? rd : '0;
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '{st: ST_RUN, ctrl: CTRL_RST, thr: THR_RST, hs: 1'b1, ls: 1'b1, default: '0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign rdata              = s_r.rdata;
   assign hs_allow           = s_r.hs;
   assign ls_allow           = s_r.ls;
   assign ls_force           = s_r.lsf;
   assign seq_off            = s_r.seq;
   assign restart            = s_r.rst_p;
   assign output_window_good = s_r.pg;
   assign irq                = s_r.irq;

endmodule
